// file: hw/fea_pkg.sv
// Shared constants, types and state layout of the flash algorithm controller
package fea_pkg;

	// ------------------------------------------------------------
	// Array geometry (in 16-bit words)
	// ------------------------------------------------------------
	localparam int MAIN_WORDS   = 64;
	localparam int SECT_WORDS   = 32;
	localparam int LINE_WORDS   = 16;
	localparam int HP_BYTES     = 16;
	localparam int HP_WORDS     = HP_BYTES / 2;
	localparam int OVL_WORDS    = 16;
	localparam int HP_COUNT     = MAIN_WORDS / HP_WORDS;
	localparam int HP_PER_LINE  = LINE_WORDS / HP_WORDS;
	localparam int MAW          = $clog2(MAIN_WORDS);
	localparam int SB           = $clog2(SECT_WORDS);
	localparam int LB           = $clog2(LINE_WORDS);
	localparam int HPB          = $clog2(HP_WORDS);
	localparam int OVB          = $clog2(OVL_WORDS);
	localparam int HPW          = $clog2(HP_COUNT);

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_ADDR    = 8'h04;
	localparam logic [7:0] REG_DATA    = 8'h08;
	localparam logic [7:0] REG_READ    = 8'h0c;
	localparam logic [7:0] REG_BUF     = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	localparam logic [7:0] REG_CTRL    = 8'h18;
	localparam logic [7:0] REG_ECC_OFF = 8'h1c;

	// Status and control bit positions
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_PERR_BIT   = 1;
	localparam int ST_EERR_BIT   = 2;
	localparam int ST_CERR_BIT   = 3;
	localparam int ST_PSUS_BIT   = 4;
	localparam int ST_ESUS_BIT   = 5;
	localparam int ST_SPACE_LSB  = 6;
	localparam int ST_SLEEP_BIT  = 8;
	localparam int CTRL_ECC2_BIT = 0;

	// Reset values
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [15:0] ADDR_RST    = 16'h0000;
	localparam logic [15:0] DATA_RST    = 16'hffff;

	// ------------------------------------------------------------
	// Command codes written to REG_CMD
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_WORD_PROG  = 8'h10;
	localparam logic [7:0] CMD_BUF_PROG   = 8'h11;
	localparam logic [7:0] CMD_ERASE      = 8'h12;
	localparam logic [7:0] CMD_PROG_SUSP  = 8'h13;
	localparam logic [7:0] CMD_ERASE_SUSP = 8'h14;
	localparam logic [7:0] CMD_RESUME     = 8'h15;
	localparam logic [7:0] CMD_ENTER_CFI  = 8'h16;
	localparam logic [7:0] CMD_ENTER_SEC  = 8'h17;
	localparam logic [7:0] CMD_EXIT_OVL   = 8'h18;
	localparam logic [7:0] CMD_SLEEP      = 8'h19;
	localparam logic [7:0] CMD_WAKE       = 8'h1a;
	localparam logic [7:0] CMD_CLR_STATUS = 8'h1b;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 100;
	localparam int RESET_RECOVERY_NS    = 1000;
	localparam int RECOVERY_CYC         = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SP_MAIN, SP_CFI, SP_SEC} fea_space_t;

	typedef enum {ST_RECOVER, ST_IDLE, ST_PROG, ST_PROG_SUSP, ST_ERASE, ST_ERASE_SUSP, ST_SLEEP} fea_state_t;

	typedef struct packed {
		fea_state_t        st;
		fea_space_t        space;
		fea_space_t        op_space;
		logic              ret_esusp;
		logic              p_word;
		logic [15:0]       p_addr;
		logic [15:0]       p_data;
		logic [HPW-1:0]    hp;
		logic [HPW-1:0]    hp_last;
		logic [31:0]       p_cnt;
		fea_space_t        e_space;
		logic [MAW-SB-1:0] e_sect;
		logic [31:0]       e_cnt;
		logic [15:0]       addr;
		logic [15:0]       data;
		logic              ecc2_en;
		logic              prog_err;
		logic              erase_err;
		logic              cmd_err;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              busy;
	} fea_regs_t;

endpackage : fea_pkg

// file: hw/fea_ctrl.sv
// Embedded algorithm controller with APB register access and a small flash array
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// [RULE_01] Identification table words: byte low, upper zero
// [RULE_02] Sleep only from idle in main space
// [RULE_03] Idle standby when nothing runs
// [RULE_04] Overlay entered by command, left by exit
// [RULE_05] Routines act on the entered address space
// [RULE_06] Erase sets ones; program clears only
// [RULE_07] Reprogramming yields AND of old, new
// [RULE_08] Erase suspend: other sectors only, no erase
// [RULE_09] Program suspend: reads outside line, no starts
// [RULE_10] Resume continues the suspended routine
// [RULE_11] Host spaces resume and next suspend apart
// [RULE_12] Finished routine returns to origin state, space
// [RULE_13] Program running: only suspend and status accepted
// [RULE_14] Erase running: only suspend and status accepted
// [RULE_15] Reset aborts routine, recovers to read mode
// [RULE_16] Programming works on aligned 16-byte half-pages
// [RULE_17] Word program clears bits zero in data
// [RULE_18] Buffer program clears line bits; partial allowed
// [RULE_19] Word and buffer half-pages mix in lines
// [RULE_20] Repeated half-page program disables its correction
// [RULE_21] Double-error option rejects repeat as error
// [RULE_22] Busy shown from routine start to end
module fea_ctrl
	import fea_pkg::*;
#(
	parameter int PROG_HP_CYCLES = 16,
	parameter int ERASE_CYCLES   = 64,
	parameter logic [7:0] ID_BYTE0 = 8'h5a // arbitrary identification byte
) (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Routine activity
	output logic             busy
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	fea_regs_t         r_q;
	fea_regs_t         r_d;
	logic [15:0]       mem_q [MAIN_WORDS];
	logic [15:0]       ovl_q [OVL_WORDS];
	logic [15:0]       buf_q [LINE_WORDS];
	logic [HP_COUNT-1:0] hp_wr_q;
	logic [HP_COUNT-1:0] ecc_off_q;

	// Combinational strobes toward the arrays
	logic              setup;
	logic              wfire;
	logic              cmd_fire;
	logic [7:0]        code;
	logic              mem_prog;
	logic              mem_erase;
	logic              buf_we;
	logic              buf_fill;
	logic [15:0]       pat [HP_WORDS];
	logic              pat_touch;
	logic              conflict;
	logic              want_prog;
	logic              want_erase;
	logic              rd_blk;
	logic [15:0]       rd_word;
	logic [31:0]       rd_val;
	logic              mapped;
	logic [HPW-1:0]    start_hp;
	logic [HPW-1:0]    hp_idx;
	logic [LB-1:0]     bidx;

	// Identification table byte for a word index
	function automatic logic [7:0] id_byte(input logic [OVB-1:0] idx);
		case (idx)
			4'h0:    id_byte = ID_BYTE0;
			4'h1:    id_byte = 8'h51;
			4'h2:    id_byte = 8'h52;
			4'h3:    id_byte = 8'h59;
			4'h4:    id_byte = 8'(MAW);
			4'h5:    id_byte = 8'(HP_BYTES);
			default: id_byte = 8'h00;
		endcase
	endfunction : id_byte

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		r_d        = r_q;
		mem_prog   = 1'b0;
		mem_erase  = 1'b0;
		buf_we     = 1'b0;
		buf_fill   = 1'b0;
		want_prog  = 1'b0;
		want_erase = 1'b0;
		conflict   = 1'b0;
		pat_touch  = 1'b0;
		hp_idx     = '0;
		bidx       = '0;
		setup      = psel & ~penable & ~r_q.pready;
		wfire      = psel & penable & pwrite & r_q.pready;
		cmd_fire   = wfire && (paddr == REG_CMD);
		code       = pwdata[7:0];

		// Half-page write pattern; word mode keeps all other words erased
		for (int i = 0; i < HP_WORDS; i++) begin
			bidx = {r_q.hp[LB-HPB-1:0], HPB'(i)};
			if (r_q.p_word)
				pat[i] = (HPB'(i) == r_q.p_addr[HPB-1:0]) ? r_q.p_data : ERASED_WORD; // RULE_17
			else
				pat[i] = buf_q[bidx]; // RULE_18
			if (pat[i] != ERASED_WORD)
				pat_touch = 1'b1;
		end

		// Repeated-program check over the half-pages that the request would touch
		if (code == CMD_WORD_PROG) begin
			start_hp = r_q.addr[MAW-1:HPB];
			conflict = hp_wr_q[start_hp] && (r_q.data != ERASED_WORD);
		end else begin
			start_hp = {r_q.addr[MAW-1:LB], (LB-HPB)'(0)};
			for (int j = 0; j < HP_PER_LINE; j++) begin
				hp_idx = {r_q.addr[MAW-1:LB], (LB-HPB)'(j)};
				for (int k = 0; k < HP_WORDS; k++) begin
					bidx = {(LB-HPB)'(j), HPB'(k)};
					if (hp_wr_q[hp_idx] && buf_q[bidx] != ERASED_WORD)
						conflict = 1'b1;
				end
			end
		end

		// Array view of the entered space; blocked where suspended work lives
		rd_blk = (r_q.st == ST_PROG) || (r_q.st == ST_ERASE) || (r_q.st == ST_RECOVER);
		if (r_q.st == ST_PROG_SUSP && r_q.space == r_q.op_space &&
		    r_q.addr[MAW-1:LB] == r_q.p_addr[MAW-1:LB])
			rd_blk = 1'b1; // RULE_09
		if (r_q.st == ST_ERASE_SUSP && r_q.space == r_q.e_space &&
		    (r_q.space == SP_SEC || r_q.addr[MAW-1:SB] == r_q.e_sect))
			rd_blk = 1'b1; // RULE_08
		case (r_q.space)
			SP_CFI:  rd_word = {8'h00, id_byte(r_q.addr[OVB-1:0])}; // RULE_01
			SP_SEC:  rd_word = ovl_q[r_q.addr[OVB-1:0]];
			default: rd_word = mem_q[r_q.addr[MAW-1:0]];
		endcase
		if (rd_blk)
			rd_word = 16'h0000;

		// Register read mux
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			REG_CMD:     rd_val = 32'h0000_0000;
			REG_ADDR:    rd_val = {16'h0000, r_q.addr};
			REG_DATA:    rd_val = {16'h0000, r_q.data};
			REG_READ:    rd_val = {16'h0000, rd_word};
			REG_BUF:     rd_val = {16'h0000, buf_q[r_q.addr[LB-1:0]]};
			REG_STATUS: begin
				rd_val[ST_BUSY_BIT]  = r_q.busy; // RULE_22
				rd_val[ST_PERR_BIT]  = r_q.prog_err;
				rd_val[ST_EERR_BIT]  = r_q.erase_err;
				rd_val[ST_CERR_BIT]  = r_q.cmd_err;
				rd_val[ST_PSUS_BIT]  = (r_q.st == ST_PROG_SUSP);
				rd_val[ST_ESUS_BIT]  = (r_q.st == ST_ERASE_SUSP) || r_q.ret_esusp;
				rd_val[ST_SPACE_LSB +: 2] = r_q.space;
				rd_val[ST_SLEEP_BIT] = (r_q.st == ST_SLEEP);
			end
			REG_CTRL:    rd_val[CTRL_ECC2_BIT] = r_q.ecc2_en;
			REG_ECC_OFF: rd_val = 32'(ecc_off_q);
			default:     mapped = 1'b0;
		endcase

		// APB answer stands one cycle; error and data drop with ready
		r_d.pready  = setup;
		r_d.prdata  = 32'h0000_0000;
		r_d.pslverr = 1'b0;
		if (setup) begin
			r_d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
			r_d.pslverr = ~mapped;
		end

		// Plain register writes
		if (wfire && paddr == REG_ADDR)
			r_d.addr = pwdata[15:0];
		if (wfire && paddr == REG_DATA)
			r_d.data = pwdata[15:0];
		if (wfire && paddr == REG_CTRL)
			r_d.ecc2_en = pwdata[CTRL_ECC2_BIT];
		// Buffer is frozen while a buffer routine may still read it
		if (wfire && paddr == REG_BUF && (r_q.st == ST_IDLE || r_q.st == ST_ERASE_SUSP))
			buf_we = 1'b1;

		// Status clear first so that a same-cycle error still lands
		if (cmd_fire && code == CMD_CLR_STATUS &&
		    (r_q.st == ST_IDLE || r_q.st == ST_ERASE_SUSP || r_q.st == ST_PROG_SUSP)) begin
			r_d.prog_err  = 1'b0;
			r_d.erase_err = 1'b0;
			r_d.cmd_err   = 1'b0;
		end

		// Routine progress
		case (r_q.st)
			ST_RECOVER: begin
				if (r_q.p_cnt == 32'd0)
					r_d.st = ST_IDLE; // RULE_15
				else
					r_d.p_cnt = r_q.p_cnt - 32'd1;
			end
			ST_PROG: begin
				if (r_q.p_cnt != 32'd0) begin
					r_d.p_cnt = r_q.p_cnt - 32'd1;
				end else begin
					mem_prog = 1'b1; // RULE_16
					if (r_q.hp == r_q.hp_last) begin
						r_d.st        = r_q.ret_esusp ? ST_ERASE_SUSP : ST_IDLE; // RULE_12
						r_d.ret_esusp = 1'b0;
						r_d.space     = r_q.op_space; // RULE_12
						buf_fill      = ~r_q.p_word;
					end else begin
						r_d.hp    = r_q.hp + HPW'(1);
						r_d.p_cnt = 32'(PROG_HP_CYCLES);
					end
				end
			end
			ST_ERASE: begin
				if (r_q.e_cnt != 32'd0) begin
					r_d.e_cnt = r_q.e_cnt - 32'd1;
				end else begin
					mem_erase = 1'b1;
					r_d.st    = ST_IDLE; // RULE_03
					r_d.space = r_q.e_space; // RULE_12
				end
			end
			default: ;
		endcase

		// Command decode against the state after progress
		if (cmd_fire) begin
			case (r_d.st)
				ST_IDLE: begin
					case (code)
						CMD_WORD_PROG, CMD_BUF_PROG: want_prog = 1'b1;
						CMD_ERASE:     want_erase = 1'b1;
						CMD_ENTER_CFI: r_d.space = SP_CFI; // RULE_04
						CMD_ENTER_SEC: r_d.space = SP_SEC; // RULE_04
						CMD_EXIT_OVL:  r_d.space = SP_MAIN; // RULE_04
						CMD_SLEEP: begin
							if (r_q.space == SP_MAIN)
								r_d.st = ST_SLEEP; // RULE_02
							else
								r_d.cmd_err = 1'b1; // RULE_02
						end
						default: ;
					endcase
				end
				ST_ERASE_SUSP: begin
					case (code)
						CMD_WORD_PROG, CMD_BUF_PROG: want_prog = 1'b1;
						CMD_ERASE:  r_d.erase_err = 1'b1; // RULE_08
						CMD_RESUME: r_d.st = ST_ERASE; // RULE_10
						CMD_SLEEP:  r_d.cmd_err = 1'b1; // RULE_02
						default: ;
					endcase
				end
				ST_PROG: begin
					if (code == CMD_PROG_SUSP)
						r_d.st = ST_PROG_SUSP; // RULE_13
				end
				ST_ERASE: begin
					if (code == CMD_ERASE_SUSP)
						r_d.st = ST_ERASE_SUSP; // RULE_14
				end
				ST_PROG_SUSP: begin
					if (code == CMD_RESUME)
						r_d.st = ST_PROG; // RULE_10
					else if (code == CMD_SLEEP)
						r_d.cmd_err = 1'b1; // RULE_09
				end
				ST_SLEEP: begin
					if (code == CMD_WAKE)
						r_d.st = ST_IDLE;
				end
				default: ;
			endcase
		end

		// Program start, checked against the entered space
		if (want_prog) begin
			if (r_q.space == SP_CFI) begin
				r_d.prog_err = 1'b1;
			end else if (r_d.st == ST_ERASE_SUSP && r_q.space == r_q.e_space &&
			             (r_q.space == SP_SEC || r_q.addr[MAW-1:SB] == r_q.e_sect)) begin
				r_d.prog_err = 1'b1; // RULE_08
			end else if (r_q.space == SP_MAIN && r_q.ecc2_en && conflict) begin
				r_d.prog_err = 1'b1; // RULE_21
			end else begin
				r_d.ret_esusp = (r_d.st == ST_ERASE_SUSP); // RULE_12
				r_d.op_space  = r_q.space; // RULE_05
				r_d.p_word    = (code == CMD_WORD_PROG);
				r_d.p_addr    = r_q.addr;
				r_d.p_data    = r_q.data;
				r_d.hp        = start_hp;
				r_d.hp_last   = (code == CMD_WORD_PROG) ? start_hp : start_hp + HPW'(HP_PER_LINE - 1);
				r_d.p_cnt     = 32'(PROG_HP_CYCLES);
				r_d.st        = ST_PROG;
			end
		end

		// Erase start
		if (want_erase) begin
			if (r_q.space == SP_CFI) begin
				r_d.erase_err = 1'b1;
			end else begin
				r_d.e_space = r_q.space; // RULE_05
				r_d.e_sect  = r_q.addr[MAW-1:SB];
				r_d.e_cnt   = 32'(ERASE_CYCLES);
				r_d.st      = ST_ERASE;
			end
		end

		r_d.busy = (r_d.st == ST_PROG) || (r_d.st == ST_ERASE) || (r_d.st == ST_RECOVER); // RULE_22
	end

	// ------------------------------------------------------------
	// Control registers; reset aborts any routine
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q           <= '0;
			r_q.st        <= ST_RECOVER; // RULE_15
			r_q.space     <= SP_MAIN; // RULE_04
			r_q.op_space  <= SP_MAIN;
			r_q.e_space   <= SP_MAIN;
			r_q.p_cnt     <= 32'(RECOVERY_CYC);
			r_q.addr      <= ADDR_RST;
			r_q.data      <= DATA_RST;
			r_q.busy      <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// Arrays; reset here stands for a fresh, erased part
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MAIN_WORDS; i++)
				mem_q[i] <= ERASED_WORD;
			for (int i = 0; i < OVL_WORDS; i++)
				ovl_q[i] <= ERASED_WORD;
			for (int i = 0; i < LINE_WORDS; i++)
				buf_q[i] <= ERASED_WORD;
			hp_wr_q   <= '0;
			ecc_off_q <= '0;
		end else begin
			// Erase returns the whole target to ones
			if (mem_erase) begin
				if (r_q.e_space == SP_SEC) begin
					for (int i = 0; i < OVL_WORDS; i++)
						ovl_q[i] <= ERASED_WORD; // RULE_06
				end else begin
					for (int i = 0; i < MAIN_WORDS; i++) begin
						if (MAW'(i) >> SB == MAW'(r_q.e_sect)) begin
							mem_q[i]           <= ERASED_WORD; // RULE_06
							hp_wr_q[i / HP_WORDS]   <= 1'b0;
							ecc_off_q[i / HP_WORDS] <= 1'b0;
						end
					end
				end
			end
			// One aligned half-page per step; AND keeps zeros sticky
			if (mem_prog) begin
				for (int i = 0; i < HP_WORDS; i++) begin
					if (r_q.op_space == SP_SEC)
						ovl_q[{r_q.hp[OVB-HPB-1:0], HPB'(i)}] <=
							ovl_q[{r_q.hp[OVB-HPB-1:0], HPB'(i)}] & pat[i]; // RULE_07
					else
						mem_q[{r_q.hp, HPB'(i)}] <= mem_q[{r_q.hp, HPB'(i)}] & pat[i]; // RULE_07
				end
				// Mixed methods share one written mark per half-page
				if (r_q.op_space == SP_MAIN && pat_touch) begin
					hp_wr_q[r_q.hp] <= 1'b1; // RULE_19
					if (hp_wr_q[r_q.hp])
						ecc_off_q[r_q.hp] <= 1'b1; // RULE_20
				end
			end
			// Unloaded buffer words stay ones so they leave data alone
			if (buf_fill) begin
				for (int i = 0; i < LINE_WORDS; i++)
					buf_q[i] <= ERASED_WORD; // RULE_18
			end else if (buf_we) begin
				buf_q[r_q.addr[LB-1:0]] <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs straight from flops
	// ------------------------------------------------------------
	assign prdata  = r_q.prdata;
	assign pready  = r_q.pready;
	assign pslverr = r_q.pslverr;
	assign busy    = r_q.busy;

endmodule : fea_ctrl

// file: verif/fea_ctrl_sva.sv
// Port-level checks of the algorithm controller
`timescale 1ns/1ps
module fea_ctrl_sva
	import fea_pkg::*;
#(
	parameter int PROG_HP_CYCLES = 16,
	parameter int ERASE_CYCLES   = 64
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Activity
	input wire logic        busy
);
	// ------------------------------------------------------------
	// Setup
	// ------------------------------------------------------------
	// Longest routine with slack; a resumed erase is never longer
	localparam int MAX_RUN = 2 * (PROG_HP_CYCLES + 1) + ERASE_CYCLES + 8;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Command write completing at this edge
	wire logic cmd_wr = psel && penable && pready && pwrite && (paddr == REG_CMD);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_rdy_setup; psel && !penable |=> pready; endproperty
	a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
	property p_err_unmap; pready && (paddr > REG_ECC_OFF) |-> pslverr; endproperty
	a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not flagged");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_rd_upper; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
	property p_wr_zero; pready && pwrite |-> prdata == 32'h0000_0000; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
	property p_busy_cause; $rose(busy) && $past(presetn) |-> $past(cmd_wr); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
	property p_busy_hold; $rose(busy) && $past(presetn) |-> busy [*3]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
	property p_busy_ends; $rose(busy) |-> ##[1:MAX_RUN] !busy; endproperty
	a_busy_ends: assert property (p_busy_ends) else $error("routine never ends");
	property p_recover; $rose(presetn) |-> busy [*8]; endproperty
	a_recover: assert property (p_recover) else $error("recovery too short");

	// Main scenarios reached
	c_cmd: cover property (cmd_wr);
	c_err: cover property (pready && pslverr);
	c_run: cover property ($rose(busy) && $past(presetn));
endmodule : fea_ctrl_sva

bind fea_ctrl fea_ctrl_sva #(
	.PROG_HP_CYCLES(PROG_HP_CYCLES),
	.ERASE_CYCLES  (ERASE_CYCLES)
) u_sva (
	.pclk   (pclk),
	.presetn(presetn),
	.psel   (psel),
	.penable(penable),
	.pwrite (pwrite),
	.paddr  (paddr),
	.pwdata (pwdata),
	.prdata (prdata),
	.pready (pready),
	.pslverr(pslverr),
	.busy   (busy)
);

// file: verif/fea_apb_host.sv
// Host memory controller model issuing APB transfers
`timescale 1ns/1ps
module fea_apb_host (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// One transfer; released data is inverted so stale values never match
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		while (presetn !== 1'b1) @(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~d;
	endtask : xfer
endmodule : fea_apb_host

// file: verif/testbench.sv
// Self-checking bench of the algorithm controller
`timescale 1ns/1ps
module testbench
	import fea_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	int          n_tests;
	int          bad_count;

	// Short counts keep the run brief but leave room to suspend
	fea_ctrl #(.PROG_HP_CYCLES(8), .ERASE_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busy(busy));
	fea_apb_host u_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: bit %b want %b", $time, got, exp);
		end
	endtask : chk_bit

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b1, a, d, r, e);
	endtask : wr

	// Read and compare the masked bits
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		u_host.xfer(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
		chk_bit(e, a > REG_ECC_OFF);
	endtask : rd

	task cmd(input logic [7:0] c);
		wr(REG_CMD, {24'h0, c});
	endtask : cmd

	task prog(input logic [15:0] a, input logic [15:0] d);
		wr(REG_ADDR, {16'h0, a});
		wr(REG_DATA, {16'h0, d});
		cmd(CMD_WORD_PROG);
	endtask : prog

	task rdw(input logic [15:0] a, input logic [15:0] x);
		wr(REG_ADDR, {16'h0, a});
		rd(REG_READ, 32'hffff_ffff, {16'h0, x});
	endtask : rdw

	// Bounded wait for the routine to end
	task wait_idle;
		int i;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (busy !== 1'b0 && i < 400);
		chk_bit(busy, 1'b0);
	endtask : wait_idle

	// Hang guard well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		finish_test;
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		presetn   = 1'b0;
		n_tests   = 0;
		bad_count = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_bit(busy, 1'b1);
		wait_idle;
		rd(REG_ADDR, 32'hffff_ffff, 32'h0000_0000);
		rd(REG_DATA, 32'hffff_ffff, 32'h0000_ffff);
		rd(8'h20, 32'hffff_ffff, 32'h0000_0000);
		$display("reset test done");
		prog(16'd3, 16'hff0f);
		wait_idle;
		rdw(16'd3, 16'hff0f);
		prog(16'd3, 16'h0ff0);
		wait_idle;
		rdw(16'd3, 16'h0f00);
		rd(REG_ECC_OFF, 32'hff, 32'h01);
		wr(REG_CTRL, 32'h1);
		prog(16'd3, 16'h0000);
		wait_idle;
		rd(REG_STATUS, 32'h2, 32'h2);
		rdw(16'd3, 16'h0f00);
		wr(REG_CTRL, 32'h0);
		cmd(CMD_CLR_STATUS);
		rd(REG_STATUS, 32'he, 32'h0);
		$display("word program test done");
		wr(REG_ADDR, 32'd3);
		cmd(CMD_ERASE);
		wait_idle;
		rdw(16'd3, 16'hffff);
		rd(REG_ECC_OFF, 32'hff, 32'h00);
		$display("erase test done");
		wr(REG_ADDR, 32'd18);
		wr(REG_BUF, 32'ha5a5);
		cmd(CMD_BUF_PROG);
		wait_idle;
		rdw(16'd18, 16'ha5a5);
		rdw(16'd19, 16'hffff);
		rd(REG_BUF, 32'hffff, 32'hffff);
		prog(16'd24, 16'h1234);
		wait_idle;
		rdw(16'd24, 16'h1234);
		rd(REG_ECC_OFF, 32'hff, 32'h00);
		prog(16'd31, 16'hfffe);
		wait_idle;
		rd(REG_ECC_OFF, 32'hff, 32'h08);
		$display("buffer program test done");
		prog(16'd40, 16'h00ff);
		cmd(CMD_ERASE_SUSP);
		cmd(CMD_PROG_SUSP);
		rd(REG_STATUS, 32'h31, 32'h10);
		rdw(16'd18, 16'ha5a5);
		cmd(CMD_WORD_PROG);
		cmd(CMD_ERASE);
		rdw(16'd40, 16'h0000);
		cmd(CMD_RESUME);
		wait_idle;
		rdw(16'd40, 16'h00ff);
		rdw(16'd18, 16'ha5a5);
		rd(REG_STATUS, 32'h3e, 32'h0);
		$display("program suspend test done");
		wr(REG_ADDR, 32'd40);
		cmd(CMD_ERASE);
		cmd(CMD_PROG_SUSP);
		cmd(CMD_ERASE_SUSP);
		rd(REG_STATUS, 32'h21, 32'h20);
		cmd(CMD_ERASE);
		rd(REG_STATUS, 32'h4, 32'h4);
		rdw(16'd40, 16'h0000);
		prog(16'd5, 16'h1111);
		wait_idle;
		rd(REG_STATUS, 32'h21, 32'h20);
		rdw(16'd5, 16'h1111);
		cmd(CMD_RESUME);
		wait_idle;
		rdw(16'd40, 16'hffff);
		cmd(CMD_CLR_STATUS);
		rd(REG_STATUS, 32'h3e, 32'h0);
		$display("erase suspend test done");
		cmd(CMD_ENTER_CFI);
		rd(REG_STATUS, 32'hc0, 32'h40);
		wr(REG_ADDR, 32'd0);
		rd(REG_READ, 32'hffff_ff00, 32'h0);
		prog(16'd1, 16'h0000);
		rd(REG_STATUS, 32'h2, 32'h2);
		cmd(CMD_SLEEP);
		rd(REG_STATUS, 32'h108, 32'h8);
		cmd(CMD_EXIT_OVL);
		cmd(CMD_CLR_STATUS);
		cmd(CMD_ENTER_SEC);
		prog(16'd2, 16'h00aa);
		wait_idle;
		rdw(16'd2, 16'h00aa);
		rd(REG_STATUS, 32'hc0, 32'h80);
		cmd(CMD_EXIT_OVL);
		rdw(16'd2, 16'hffff);
		cmd(CMD_SLEEP);
		rd(REG_STATUS, 32'h100, 32'h100);
		cmd(CMD_WAKE);
		rd(REG_STATUS, 32'h100, 32'h0);
		$display("overlay test done");
		prog(16'd50, 16'h0000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_bit(busy, 1'b1);
		wait_idle;
		rdw(16'd50, 16'hffff);
		prog(16'd50, 16'h0000);
		wait_idle;
		rdw(16'd50, 16'h0000);
		$display("reset abort test done");
		finish_test;
	end
endmodule : testbench
